// ---- testbench/dctd_mem_model.sv ----
// Purpose: System bus memory model on the far side of the DMA engine.
// Assumes: A request stays on bus_req until a one-cycle bus_ack.
// Notes: Read data is the address xor a key; flash writes are counted.
`include "dctd_map.svh"
module dctd_mem_model
  import dctd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] lat,
  input wire logic bus_req,
  input wire dctd_bus_req_s bus_cmd,
  output logic bus_ack,
  output logic [31:0] bus_rdata,
  output logic [7:0] flash_wr
);
  logic [3:0] cnt;
  logic flash_hit;
  assign flash_hit = bus_cmd.addr >= `DCTD_FLASH_BASE && bus_cmd.addr <= `DCTD_FLASH_LIMIT;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_ack <= 1'b0;
      bus_rdata <= 32'h00000000;
      cnt <= 4'h0;
      flash_wr <= 8'h00;
    end else if (bus_ack || !bus_req) begin
      // Released data toggles so a late sample never sees stale data.
      bus_ack <= 1'b0;
      bus_rdata <= ~bus_rdata;
      cnt <= 4'h0;
    end else if (cnt >= lat) begin
      bus_ack <= 1'b1;
      bus_rdata <= bus_cmd.we ? ~bus_rdata : bus_cmd.addr ^ 32'h5a5a5a5a;
      flash_wr <= flash_wr + {7'h00, bus_cmd.we & flash_hit};
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench for the DMA engine over APB.
// Assumes: Memory model answers after lat wait cycles.
// Notes: Writes on the system bus are logged and compared in order.
module testbench
  import dctd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, bus_req, bus_ack;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, trig, done_o, bus_rdata, wd, r;
  logic [3:0] lat;
  logic [7:0] flash_wr;
  dctd_bus_req_s bus_cmd;
  logic [31:0] wq[$];
  int err_total, tests_run, pulses, run, base, cyc, last_end, gap;
  dctd_engine i_dut(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .channel_trigger_input(trig), .completion_pulse_output(done_o),
    .bus_req(bus_req), .bus_cmd(bus_cmd), .bus_ack(bus_ack), .bus_rdata(bus_rdata));
  dctd_mem_model i_mem(.pclk(pclk), .presetn(presetn), .lat(lat), .bus_req(bus_req),
    .bus_cmd(bus_cmd), .bus_ack(bus_ack), .bus_rdata(bus_rdata), .flash_wr(flash_wr));
  task automatic results();
    $display("Errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x) begin
      err_total++;
      $display("Error t=%0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      results();
    end
    r = prdata;
    chk({31'h0, pslverr}, {31'h0, a >= 12'h480});
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  function automatic logic [11:0] cfg(input int ch);
    return 12'h400 + 12'(ch * 4);
  endfunction
  function automatic logic [31:0] ctl(input logic [15:0] n1, input logic [1:0] sz, tt, md,
      input logic inv);
    return {7'h00, inv, md, tt, 2'b11, sz, n1};
  endfunction
  task automatic desc(input int ch, input logic [31:0] s, dd, c, st);
    apb(1'b1, 12'(ch * 32), s);
    apb(1'b1, 12'(ch * 32 + 4), dd);
    apb(1'b1, 12'(ch * 32 + 8), c);
    apb(1'b1, 12'(ch * 32 + 12), st);
  endtask
  task automatic wp(input int n);
    int k;
    for (k = 0; k < 3000 && pulses < n; k++) @(posedge pclk);
    if (pulses < n) begin
      err_total++;
      results();
    end
  endtask
  task automatic trg(input int ch);
    @(posedge pclk);
    trig[ch] <= 1'b1;
    repeat (2) @(posedge pclk);
    trig[ch] <= 1'b0;
  endtask
  task automatic poll(input logic [11:0] a, input int b);
    int k;
    for (k = 0; k < 30; k++) begin
      apb(1'b0, a, 32'h0);
      if (r[b] === 1'b1) break;
    end
  endtask
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // Completion pulses are measured here; each must be exactly two cycles wide.
  always @(posedge pclk) begin
    if (bus_req && bus_ack && bus_cmd.we) begin
      wq.push_back(bus_cmd.addr);
      wd = bus_cmd.wdata;
    end
    cyc++;
    if (|done_o) begin
      run++;
    end else if (run != 0) begin
      chk(run, 2);
      pulses++;
      run = 0;
      gap = cyc - last_end;
      last_end = cyc;
    end
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, trig, lat} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc(cfg(0), 32'h0000000c);
    rdc(12'h008, 32'h00000000);
    rdc(12'h480, 32'h00000000);
    desc(0, 32'h20000000, 32'h20001000, ctl(16'h1, 2'h2, TT_PULSE, MODE_SINGLE, 1'b0),
      32'h80000000);
    apb(1'b1, cfg(0), 32'h00000101);
    wp(1);
    chk(wd, 32'h20000000 ^ 32'h5a5a5a5a);
    chk(wq.size(), 1);
    rdc(12'h00c, 32'h80000001);
    apb(1'b1, cfg(0), 32'h00000101);
    wp(2);
    chk(wq[1], 32'h20001004);
    rdc(12'h00c, 32'h80000000);
    desc(1, 32'h20000100, 32'h20001100, ctl(16'h2, 2'h1, TT_PULSE, MODE_ENTIRE, 1'b1),
      32'h80000000);
    apb(1'b1, cfg(1), 32'h00000101);
    wp(3);
    chk(wq.size(), 5);
    chk(wq[4], 32'h20001104);
    rdc(12'h02c, 32'h00000000);
    apb(1'b1, cfg(1), 32'h00000101);
    poll(12'h02c, 30);
    chk(r, 32'h40000000);
    rdc(cfg(1), 32'h00000000);
    desc(2, 32'h20000200, 32'h10000000, ctl(16'h0, 2'h2, TT_PULSE, MODE_SINGLE, 1'b0),
      32'h80000000);
    apb(1'b1, cfg(2), 32'h00000101);
    poll(12'h04c, 29);
    chk(r, 32'ha0000000);
    chk(flash_wr, 0);
    chk(wq.size(), 5);
    // A slow bus keeps channel 6 busy while the other triggers arrive.
    lat <= 4'h8;
    for (int ch = 3; ch <= 6; ch++) begin
      desc(ch, 32'h20000000 + 32'(ch * 256), 32'h20002000 + 32'(ch * 256),
        ctl(ch == 6 ? 16'h7 : 16'h0, 2'h2, TT_PULSE, ch == 6 ? MODE_ENTIRE : MODE_SINGLE,
        1'b0), 32'h80000000);
    end
    apb(1'b1, cfg(3), 32'h00000007);
    apb(1'b1, cfg(4), 32'h0000000f);
    apb(1'b1, cfg(5), 32'h00000001);
    base = pulses;
    apb(1'b1, cfg(6), 32'h00000101);
    trg(4);
    trg(4);
    trg(3);
    trg(5);
    rdc(cfg(3), 32'h00000207);
    wp(base + 3);
    chk(wq[13], 32'h20002300);
    chk(wq[14], 32'h20002400);
    repeat (200) @(posedge pclk);
    chk(wq.size(), 15);
    lat <= 4'h0;
    // Chain mode on descriptor 0 hands over to descriptor 1, which then stops.
    desc(8, 32'h20000800, 32'h20002800, ctl(16'h0, 2'h0, TT_PULSE, MODE_CHAIN, 1'b0),
      32'h80000000);
    apb(1'b1, 12'h110, 32'h20000900);
    apb(1'b1, 12'h114, 32'h20002900);
    apb(1'b1, 12'h118, ctl(16'h1, 2'h0, TT_PULSE, MODE_ENTIRE, 1'b0));
    apb(1'b1, 12'h11c, 32'h80000000);
    base = pulses;
    apb(1'b1, cfg(8), 32'h00000101);
    wp(base + 2);
    chk(wq.size(), 18);
    chk(wq[15], 32'h20002800);
    chk(wq[17], 32'h20002901);
    rdc(cfg(8), 32'h00000011);
    // Level type with a bounded hold-off, and the trigger is dropped at the end.
    desc(7, 32'h20000700, 32'h20002700, ctl(16'h3, 2'h2, TT_LVL4, MODE_SINGLE, 1'b0),
      32'h80000000);
    apb(1'b1, cfg(7), 32'h00000003);
    base = pulses;
    trig[7] <= 1'b1;
    wp(base + 3);
    chk(gap, 10);
    trig[7] <= 1'b0;
    results();
  end
endmodule

// ---- verilog/dctd_engine.sv ----
// Purpose: Multi-channel DMA engine with two descriptors per channel and an APB slave.
// Assumes: Trigger inputs and the system bus answer are synchronous to pclk.
// Notes: Descriptors are flip-flops; element progress lives in the status word.
// Notes on behaviour
// - Thirty-two channels, each with trigger input, completion output and two descriptors.
// - Elements are byte, halfword or word, chosen per descriptor.
// - A descriptor moves up to 65,536 elements; control holds count minus one.
// - Single mode moves one element per accepted trigger, then waits.
// - Entire and chain modes move the whole descriptor; chain then triggers the other.
// - Two descriptors per channel; software may rewrite the idle one anytime.
// - Descriptor is four words: source, destination, control and status.
// - Optionally clear the valid bit when a descriptor completes.
// - Trigger on invalid descriptor skips it, disables channel, flags status.
// - A channel starts from its hardware trigger, a register write, or both.
// - With hardware trigger disabled only register writes start the channel.
// - A trigger rising while busy sets the channel pending flag.
// - After each transfer the highest-priority pending channel starts next.
// - One pending request per channel; further triggers merge into it.
// - Level triggers hold off four, eight or indefinite cycles after completion.
// - Trigger falling during hold-off re-triggers only on the next high.
// - Trigger high through hold-off re-triggers at expiry; indefinite waits for low.
// - Completion output pulses high two cycles at the end of each transfer.
// - Never write to flash; flash is a source only.
// - Priority zero is highest; reset gives the lowest level.
// - Trigger type: standard pulse, level wait four, level wait eight, unknown pulse.
// - With increment enabled addresses step by the element width in bytes.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
module dctd_engine
  import dctd_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [31:0] channel_trigger_input,
  output logic [31:0] completion_pulse_output,
  output logic bus_req,
  output dctd_bus_req_s bus_cmd,
  input wire logic bus_ack,
  input wire logic [31:0] bus_rdata
);

  function automatic logic [31:0] elem_addr(input logic [31:0] base, input logic [15:0] n,
                                            input logic [1:0] sz, input logic inc);
    logic [31:0] off;
    off = {16'h0000, n} << ((sz == 2'h3) ? 2'h2 : sz);
    return inc ? 32'(base + off) : base;
  endfunction

  function automatic logic in_flash(input logic [31:0] a);
    return (a >= `DCTD_FLASH_BASE) && (a <= `DCTD_FLASH_LIMIT);
  endfunction

  function automatic logic [4:0] pick(input logic [31:0] req, input logic [63:0] pr);
    logic [4:0] best;
    logic [1:0] bp;
    logic found;
    best = 5'h00;
    bp = 2'h3;
    found = 1'b0;
    for (int i = 0; i < `DCTD_NCH; i++) begin
      if (req[i] && (!found || pr[2*i +: 2] < bp)) begin
        best = 5'(i);
        bp = pr[2*i +: 2];
        found = 1'b1;
      end
    end
    return best;
  endfunction

  dctd_word_t desc_r [0:255];
  logic [31:0] en_r;
  logic [31:0] hwen_r;
  logic [31:0] act_r;
  logic [63:0] prio_r;
  logic [31:0] pend_r;
  logic [31:0] cmp_a_r;
  logic [31:0] cmp_out_r;
  logic [31:0] trig_d_r;
  dctd_state_e state_r;
  logic [4:0] ch_r;
  logic ready_r;
  logic [31:0] prdata_r;
  logic bus_req_r;
  dctd_bus_req_s bus_cmd_r;
  logic [31:0] hw_req;
  logic [31:0] hold_start;
  dctd_state_e state_nxt;
  dctd_word_t st_nxt;

  // APB decode; one wait state so read data comes from a flip-flop.
  wire apb_acc = psel & penable;
  wire apb_wr = apb_acc & pwrite & ready_r;
  wire is_desc = paddr[11:10] == `DCTD_DESC_PAGE;
  wire is_chan = paddr[11:7] == `DCTD_CHAN_PAGE;
  wire [4:0] pch = paddr[6:2];
  wire [7:0] pidx = paddr[9:2];
  wire desc_wr = apb_wr & is_desc;
  wire chan_wr = apb_wr & is_chan;

  // Current descriptor of the granted channel.
  wire act = act_r[ch_r];
  wire [7:0] dsrc = {ch_r, act, `DCTD_DW_SRC};
  wire [7:0] ddst = {ch_r, act, `DCTD_DW_DST};
  wire [7:0] dctl = {ch_r, act, `DCTD_DW_CTL};
  wire [7:0] dst_i = {ch_r, act, `DCTD_DW_ST};
  wire [31:0] c_ctl = desc_r[dctl];
  wire [31:0] c_st = desc_r[dst_i];
  wire [15:0] idx = c_st[`DCTD_ST_IDX_LO +: 16];
  wire [15:0] last = c_ctl[`DCTD_CTL_LAST_LO +: 16];
  wire [1:0] esz = c_ctl[`DCTD_CTL_SIZE_LO +: 2];
  wire [1:0] mode = c_ctl[`DCTD_CTL_MODE_LO +: 2];
  wire [1:0] ttype = c_ctl[`DCTD_CTL_TTYPE_LO +: 2];
  wire last_el = idx == last;
  wire [31:0] src_a = elem_addr(desc_r[dsrc], idx, esz, c_ctl[`DCTD_CTL_SINC]);
  wire [31:0] dst_a = elem_addr(desc_r[ddst], idx, esz, c_ctl[`DCTD_CTL_DINC]);

  // Engine events.
  wire [31:0] elig = pend_r & en_r;
  wire [4:0] pick_w = pick(elig, prio_r);
  wire grant = (state_r == S_IDLE) & (|elig);
  wire ld_bad = (state_r == S_LOAD) & ~c_st[`DCTD_ST_VALID];
  wire ld_ok = (state_r == S_LOAD) & c_st[`DCTD_ST_VALID];
  wire rd_done = (state_r == S_RD) & bus_ack;
  wire flash_err = rd_done & in_flash(dst_a);
  wire wr_done = (state_r == S_WR) & bus_ack;
  wire desc_end = wr_done & last_el;
  wire xfer_end = wr_done & (last_el | (mode == MODE_SINGLE));
  wire chain_go = desc_end & (c_ctl[`DCTD_CTL_CHAIN] | (mode == MODE_CHAIN));
  wire st_we = ld_bad | flash_err | wr_done;
  wire [31:0] ch_hot = 32'h00000001 << ch_r;
  wire [31:0] clr = grant ? (32'h00000001 << pick_w) : 32'h00000000;
  wire [31:0] fw_set = (chan_wr & pwdata[`DCTD_CFG_FWTRIG]) ? (32'h00000001 << pch) : 32'h00000000;
  wire [31:0] auto_set = (desc_end & (mode == MODE_CHAIN)) ? ch_hot : 32'h00000000;
  wire [31:0] pend_set = hw_req | fw_set | auto_set;
  wire busy_here = (state_r != S_IDLE) & (ch_r == pch);
  wire [31:0] chan_rd = {21'h000000, busy_here, pend_r[pch], 1'b0, 3'h0, act_r[pch],
                         prio_r[2*pch +: 2], hwen_r[pch], en_r[pch]};
  wire [31:0] rd_mux = is_desc ? desc_r[pidx] : (is_chan ? chan_rd : 32'h00000000);

  assign pready = ready_r;
  assign pslverr = ready_r & ~(is_desc | is_chan);
  assign prdata = prdata_r;
  assign bus_req = bus_req_r;
  assign bus_cmd = bus_cmd_r;
  assign completion_pulse_output = cmp_out_r;

  always_comb begin
    st_nxt = c_st;
    if (ld_bad) begin
      st_nxt[`DCTD_ST_ERR_INV] = 1'b1;
    end else if (flash_err) begin
      st_nxt[`DCTD_ST_ERR_FLASH] = 1'b1;
      st_nxt[`DCTD_ST_IDX_LO +: 16] = 16'h0000;
    end else if (desc_end) begin
      st_nxt[`DCTD_ST_IDX_LO +: 16] = 16'h0000;
      if (c_ctl[`DCTD_CTL_INVAL]) begin
        st_nxt[`DCTD_ST_VALID] = 1'b0;
      end
    end else begin
      st_nxt[`DCTD_ST_IDX_LO +: 16] = 16'(idx + 16'h0001);
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE: state_nxt = grant ? S_LOAD : S_IDLE;
      S_LOAD: state_nxt = ld_bad ? S_IDLE : S_RD;
      S_RD: state_nxt = rd_done ? (flash_err ? S_IDLE : S_WR) : S_RD;
      // Each element re-enters LOAD so the address uses the updated index.
      S_WR: state_nxt = wr_done ? (xfer_end ? S_IDLE : S_LOAD) : S_WR;
      default: state_nxt = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      ready_r <= apb_acc & ~ready_r;
      if (apb_acc & ~ready_r & ~pwrite) begin
        prdata_r <= rd_mux;
      end
    end
  end

  // The engine's status update is placed last so it wins a same-cycle software write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 256; i++) begin
        desc_r[i] <= `DCTD_DESC_RESET;
      end
    end else begin
      if (desc_wr) begin
        desc_r[pidx] <= pwdata;
      end
      if (st_we) begin
        desc_r[dst_i] <= st_nxt;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_r <= 32'h00000000;
      hwen_r <= 32'h00000000;
      act_r <= 32'h00000000;
      prio_r <= {`DCTD_NCH{`DCTD_PRIO_RESET}};
    end else begin
      if (chan_wr) begin
        en_r[pch] <= pwdata[`DCTD_CFG_EN];
        hwen_r[pch] <= pwdata[`DCTD_CFG_HWEN];
        prio_r[2*pch +: 2] <= pwdata[`DCTD_CFG_PRIO_LO +: 2];
        act_r[pch] <= pwdata[`DCTD_CFG_ACT];
      end
      if (ld_bad | flash_err) begin
        en_r[ch_r] <= 1'b0;
      end
      if (chain_go) begin
        act_r[ch_r] <= ~act;
      end
    end
  end

  // A request set in the cycle of its grant survives, so no trigger is lost.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_r <= 32'h00000000;
    end else begin
      pend_r <= (pend_r & ~clr) | pend_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= S_IDLE;
      ch_r <= 5'h00;
      bus_req_r <= 1'b0;
      bus_cmd_r <= '0;
    end else begin
      state_r <= state_nxt;
      if (grant) begin
        ch_r <= pick_w;
      end
      if (ld_ok) begin
        bus_req_r <= 1'b1;
        bus_cmd_r <= '{we: 1'b0, size: esz, addr: src_a, wdata: 32'h00000000};
      end else if (rd_done & ~flash_err) begin
        bus_req_r <= 1'b1;
        bus_cmd_r <= '{we: 1'b1, size: esz, addr: dst_a, wdata: bus_rdata};
      end else if (bus_ack) begin
        bus_req_r <= 1'b0;
      end
    end
  end

  for (genvar c = 0; c < `DCTD_NCH; c++) begin : g_ch
    logic [3:0] cnt_r;
    logic low_r;
    wire trig = channel_trigger_input[c];
    wire rise = trig & ~trig_d_r[c];
    // Indefinite and pulse types load no count, so only a fresh rise re-triggers.
    wire expire = (cnt_r == 4'h1) & trig & ~low_r;
    assign hold_start[c] = xfer_end & (ch_r == 5'(c));
    assign hw_req[c] = hwen_r[c] & (rise | expire);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        trig_d_r[c] <= 1'b0;
        cnt_r <= 4'h0;
        low_r <= 1'b0;
        cmp_a_r[c] <= 1'b0;
        cmp_out_r[c] <= 1'b0;
      end else begin
        trig_d_r[c] <= trig;
        cmp_a_r[c] <= hold_start[c];
        cmp_out_r[c] <= hold_start[c] | cmp_a_r[c];
        if (hold_start[c]) begin
          cnt_r <= (ttype == TT_LVL4) ? `DCTD_HOLD_SHORT :
                   ((ttype == TT_LVL8) ? `DCTD_HOLD_LONG : 4'h0);
          low_r <= 1'b0;
        end else if (cnt_r != 4'h0) begin
          cnt_r <= cnt_r - 4'h1;
          if (!trig) begin
            low_r <= 1'b1;
          end
        end
      end
    end

    a_pulse_two_cycles: assert property (@(posedge pclk) disable iff (!presetn)
      hold_start[c] |=> cmp_out_r[c] [*2] ##1 !cmp_out_r[c])
      else $error("completion pulse is not two cycles wide");
    a_rise_pending: assert property (@(posedge pclk) disable iff (!presetn)
      hwen_r[c] && rise |=> pend_r[c])
      else $error("trigger rise did not set pending");
    a_hold_expiry: assert property (@(posedge pclk) disable iff (!presetn)
      hwen_r[c] && cnt_r == 4'h1 && trig && !low_r |=> pend_r[c])
      else $error("held trigger did not re-trigger at hold-off expiry");
    a_hw_disabled: assert property (@(posedge pclk) disable iff (!presetn)
      !hwen_r[c] && !fw_set[c] && !auto_set[c] && !pend_r[c] |=> !pend_r[c])
      else $error("pending set with hardware trigger disabled");
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_flash_guard: assert property (bus_req_r && bus_cmd_r.we |-> !in_flash(bus_cmd_r.addr))
    else $error("write request aimed at flash");
  a_invalid_stop: assert property (ld_bad |=> state_r == S_IDLE && !en_r[$past(ch_r)])
    else $error("invalid descriptor did not stop the channel");
  a_single_stop: assert property (wr_done && mode == MODE_SINGLE |=> state_r == S_IDLE)
    else $error("single mode moved more than one element");
  a_entire_loop: assert property (
    wr_done && !last_el && mode != MODE_SINGLE |=> state_r == S_LOAD ##1 bus_req_r)
    else $error("entire mode did not continue with the next element");
  a_grant_clear: assert property (grant && !pend_set[pick_w] |=> !pend_r[$past(pick_w)])
    else $error("granted request stayed pending");
  a_step_word: assert property (
    ld_ok && esz == 2'h2 && c_ctl[`DCTD_CTL_SINC] |=>
    bus_cmd_r.addr == 32'(desc_r[$past(dsrc)] + {14'h0000, $past(idx), 2'h0}))
    else $error("word source address step is wrong");

  c_chain_end: cover property (desc_end && mode == MODE_CHAIN);
  c_invalid: cover property (ld_bad);
  c_flash_err: cover property (flash_err);
  c_expiry: cover property (g_ch[0].expire && hwen_r[0]);

endmodule

// ---- verilog/dctd_map.svh ----
// Purpose: Offsets, field positions, reset values and counts of the DMA engine.
// Assumes: Byte addresses on a 12-bit APB address, one 32-bit word per register.
// Notes: Included by the package and the memory model; definitions only.
`ifndef DCTD_MAP_SVH
`define DCTD_MAP_SVH
`define DCTD_NCH 32
`define DCTD_DESC_PAGE 2'h0
`define DCTD_CHAN_PAGE 5'h08
`define DCTD_DW_SRC 2'h0
`define DCTD_DW_DST 2'h1
`define DCTD_DW_CTL 2'h2
`define DCTD_DW_ST 2'h3
`define DCTD_CTL_LAST_LO 0
`define DCTD_CTL_SIZE_LO 16
`define DCTD_CTL_SINC 18
`define DCTD_CTL_DINC 19
`define DCTD_CTL_TTYPE_LO 20
`define DCTD_CTL_MODE_LO 22
`define DCTD_CTL_INVAL 24
`define DCTD_CTL_CHAIN 25
`define DCTD_ST_IDX_LO 0
`define DCTD_ST_ERR_FLASH 29
`define DCTD_ST_ERR_INV 30
`define DCTD_ST_VALID 31
`define DCTD_CFG_EN 0
`define DCTD_CFG_HWEN 1
`define DCTD_CFG_PRIO_LO 2
`define DCTD_CFG_ACT 4
`define DCTD_CFG_FWTRIG 8
`define DCTD_CFG_PEND 9
`define DCTD_CFG_BUSY 10
`define DCTD_PRIO_RESET 2'h3
`define DCTD_DESC_RESET 32'h00000000
`define DCTD_HOLD_SHORT 4'h4
`define DCTD_HOLD_LONG 4'h8
`define DCTD_FLASH_BASE 32'h10000000
`define DCTD_FLASH_LIMIT 32'h1fffffff
`endif

// ---- verilog/dctd_pkg.sv ----
// Purpose: Types shared by the DMA engine and its bench.
// Assumes: Field positions live in dctd_map.svh.
// Notes: Encodings of trigger type, transfer mode and engine state.
`include "dctd_map.svh"
package dctd_pkg;
  typedef logic [31:0] dctd_word_t;
  typedef enum logic [1:0] {
    TT_PULSE = 2'b00,
    TT_LVL4 = 2'b01,
    TT_LVL8 = 2'b10,
    TT_UNKNOWN = 2'b11
  } dctd_ttype_e;
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'b00,
    MODE_ENTIRE = 2'b01,
    MODE_CHAIN = 2'b10
  } dctd_mode_e;
  typedef enum logic [1:0] {
    S_IDLE = 2'b00,
    S_LOAD = 2'b01,
    S_RD = 2'b10,
    S_WR = 2'b11
  } dctd_state_e;
  typedef struct packed {
    logic we;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dctd_bus_req_s;
endpackage
